// file: hdl/sfg_pkg.sv
// Constants for the readout-format and gain block
package sfg_pkg;
    // Register offsets
    localparam logic [7:0] OFS_START_A   = 8'h01;
    localparam logic [7:0] OFS_START_B   = 8'h02;
    localparam logic [7:0] OFS_ROW_CNT   = 8'h03;
    localparam logic [7:0] OFS_COL_CNT   = 8'h04;
    localparam logic [7:0] OFS_HBLANK    = 8'h05;
    localparam logic [7:0] OFS_VBLANK    = 8'h06;
    localparam logic [7:0] OFS_RD_CTRL   = 8'h20;
    localparam logic [7:0] OFS_ROW_RED   = 8'h22;
    localparam logic [7:0] OFS_COL_RED   = 8'h23;
    localparam logic [7:0] OFS_GAIN_G1   = 8'h2B;
    localparam logic [7:0] OFS_GAIN_B    = 8'h2C;
    localparam logic [7:0] OFS_GAIN_R    = 8'h2D;
    localparam logic [7:0] OFS_GAIN_G2   = 8'h2E;
    localparam logic [7:0] OFS_GAIN_ALL  = 8'h35;
    localparam logic [7:0] OFS_BLK_CTRL  = 8'h40;
    // Reset values
    localparam logic [15:0] RST_START    = 16'h0000;
    localparam logic [15:0] RST_ROW_CNT  = 16'h05FF;
    localparam logic [15:0] RST_COL_CNT  = 16'h07FF;
    localparam logic [15:0] RST_HBLANK   = 16'h0016;
    localparam logic [15:0] RST_VBLANK   = 16'h0028;
    localparam logic [15:0] RST_ZERO     = 16'h0000;
    localparam logic [15:0] RST_GAIN     = 16'h0008;
    // Field positions
    localparam int SKIP_LSB   = 0;
    localparam int SKIP_MSB   = 2;
    localparam int BIN_LSB    = 4;
    localparam int BIN_MSB    = 5;
    localparam int LVF_LSB    = 9;
    localparam int LVF_MSB    = 10;
    localparam int G1ST_BIT   = 6;
    localparam int G2ND_MSB   = 5;
    localparam int DIG_LSB    = 8;
    localparam int DIG_MSB    = 14;
    localparam int BLK_AUTO   = 15;
    // Line-valid output formats
    localparam logic [1:0] LVF_NORMAL = 2'h0;
    localparam logic [1:0] LVF_CONT   = 2'h1;
    // Bin codes (factor minus one)
    localparam logic [1:0] BIN_2X     = 2'h1;
    // Gain arithmetic: two eighths scale factors
    localparam int GAIN_SHIFT = 6;
    localparam logic [7:0] DIG_ONE = 8'h08;
    // Divide by nine as multiply by 57 then shift by 9
    localparam logic [5:0] NINTH_MUL   = 6'h39;
    localparam int         NINTH_SHIFT = 9;
    // Colour plane indexes
    localparam logic [1:0] COL_R  = 2'h0;
    localparam logic [1:0] COL_G1 = 2'h1;
    localparam logic [1:0] COL_G2 = 2'h2;
    localparam logic [1:0] COL_B  = 2'h3;
endpackage : sfg_pkg

// file: hdl/sfg_readout.sv
// Windowed skip/bin readout with per-colour gain and row-valid formats
`timescale 1ns/1ps
module sfg_readout #(
    parameter int PIX_W = 12,
    parameter int ADR_W = 12
) (
    input  wire logic             ref_clk,
    input  wire logic             rst_n,
    input  wire logic [7:0]       reg_addr,
    input  wire logic [15:0]      reg_wdata,
    input  wire logic             reg_wr,
    input  wire logic             reg_rd,
    output logic      [15:0]      reg_rdata,
    output logic      [ADR_W-1:0] arr_row,
    output logic      [ADR_W-1:0] arr_col,
    input  wire logic [PIX_W-1:0] arr_data,
    output logic      [PIX_W-1:0] pix_data,
    output logic                  pix_valid,
    input  wire logic             pix_ready,
    output logic                  frame_valid,
    output logic                  line_valid
);
    typedef enum logic [4:0] {
        SFG_VBLANK = 5'h01,
        SFG_READ   = 5'h02,
        SFG_WAIT   = 5'h04,
        SFG_PUSH   = 5'h08,
        SFG_HBLANK = 5'h10
    } sfg_state_t;

    localparam int SUM_W = PIX_W + 4;

    logic [15:0] start_a_reg, start_b_reg, row_cnt_reg, col_cnt_reg;
    logic [15:0] hblank_reg, vblank_reg, rd_ctrl_reg;
    logic [15:0] row_red_reg, col_red_reg, blk_ctrl_reg;
    logic [15:0] gain_reg [4];

    sfg_state_t       state_reg;
    logic [15:0]      row_off_reg, col_off_reg;
    logic             row_ph_reg, col_ph_reg;
    logic [1:0]       bi_reg, bj_reg;
    logic [SUM_W-1:0] sum_reg;
    logic [1:0]       plane_reg;
    logic [15:0]      blank_cnt_reg, vrow_reg;
    logic             vb_line_reg, fv_reg;
    logic [PIX_W-1:0] blk_est_reg, frame_min_reg;

    // Effective factors: skip never below bin
    logic [2:0] row_skip, col_skip;
    logic [1:0] row_bin, col_bin;
    always_comb begin
        row_bin  = row_red_reg[sfg_pkg::BIN_MSB:sfg_pkg::BIN_LSB];
        col_bin  = col_red_reg[sfg_pkg::BIN_MSB:sfg_pkg::BIN_LSB];
        row_skip = row_red_reg[sfg_pkg::SKIP_MSB:sfg_pkg::SKIP_LSB];
        col_skip = col_red_reg[sfg_pkg::SKIP_MSB:sfg_pkg::SKIP_LSB];
        if ({1'b0, row_bin} > row_skip) begin
            row_skip = {1'b0, row_bin};
        end
        if ({1'b0, col_bin} > col_skip) begin
            col_skip = {1'b0, col_bin};
        end
    end

    // Offset of the next read-out pair member: pairs 0,1 then jump
    function automatic logic [15:0] next_off(input logic [15:0] off,
                                             input logic        ph,
                                             input logic [2:0]  skip);
        if (!ph) begin
            next_off = off + 16'h0001;
        end else begin
            next_off = off + {12'h000, skip, 1'b0} - 16'h0001
                       + 16'h0002;
        end
    endfunction : next_off

    // Bayer plane from array parity: even row R G, odd row G B
    function automatic logic [1:0] plane_of(input logic r0, input logic c0);
        unique case ({r0, c0})
            2'b00:   plane_of = sfg_pkg::COL_R;
            2'b01:   plane_of = sfg_pkg::COL_G1;
            2'b10:   plane_of = sfg_pkg::COL_G2;
            default: plane_of = sfg_pkg::COL_B;
        endcase
    endfunction : plane_of

    logic [15:0] arow_w, acol_w, row_nx, col_nx;
    logic        last_bi, last_bj, row_end, frame_end;
    always_comb begin
        arow_w  = start_b_reg + row_off_reg + {13'h0, bj_reg, 1'b0};
        acol_w  = start_a_reg + col_off_reg + {13'h0, bi_reg, 1'b0};
        row_nx  = next_off(row_off_reg, row_ph_reg, row_skip);
        col_nx  = next_off(col_off_reg, col_ph_reg, col_skip);
        last_bi = (bi_reg == col_bin);
        last_bj = (bj_reg == row_bin);
        // Window spans count plus one rows and columns
        row_end   = (col_nx > col_cnt_reg);
        frame_end = (row_nx > row_cnt_reg);
    end

    // Register file; a global gain write lands in all four colours
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            start_a_reg  <= sfg_pkg::RST_START;
            start_b_reg  <= sfg_pkg::RST_START;
            row_cnt_reg  <= sfg_pkg::RST_ROW_CNT;
            col_cnt_reg  <= sfg_pkg::RST_COL_CNT;
            hblank_reg   <= sfg_pkg::RST_HBLANK;
            vblank_reg   <= sfg_pkg::RST_VBLANK;
            rd_ctrl_reg  <= sfg_pkg::RST_ZERO;
            row_red_reg  <= sfg_pkg::RST_ZERO;
            col_red_reg  <= sfg_pkg::RST_ZERO;
            blk_ctrl_reg <= sfg_pkg::RST_ZERO;
            for (int i = 0; i < 4; i++) begin
                gain_reg[i] <= sfg_pkg::RST_GAIN;
            end
        end else if (reg_wr) begin
            unique case (reg_addr)
                sfg_pkg::OFS_START_A:  start_a_reg  <= reg_wdata;
                sfg_pkg::OFS_START_B:  start_b_reg  <= reg_wdata;
                sfg_pkg::OFS_ROW_CNT:  row_cnt_reg  <= reg_wdata;
                sfg_pkg::OFS_COL_CNT:  col_cnt_reg  <= reg_wdata;
                sfg_pkg::OFS_HBLANK:   hblank_reg   <= reg_wdata;
                sfg_pkg::OFS_VBLANK:   vblank_reg   <= reg_wdata;
                sfg_pkg::OFS_RD_CTRL:  rd_ctrl_reg  <= reg_wdata;
                sfg_pkg::OFS_ROW_RED:  row_red_reg  <= reg_wdata;
                sfg_pkg::OFS_COL_RED:  col_red_reg  <= reg_wdata;
                sfg_pkg::OFS_BLK_CTRL: blk_ctrl_reg <= reg_wdata;
                // Index follows the colour plane codes used by plane_of
                sfg_pkg::OFS_GAIN_G1:  gain_reg[1]  <= reg_wdata;
                sfg_pkg::OFS_GAIN_B:   gain_reg[3]  <= reg_wdata;
                sfg_pkg::OFS_GAIN_R:   gain_reg[0]  <= reg_wdata;
                sfg_pkg::OFS_GAIN_G2:  gain_reg[2]  <= reg_wdata;
                sfg_pkg::OFS_GAIN_ALL: begin
                    for (int i = 0; i < 4; i++) begin
                        gain_reg[i] <= reg_wdata;
                    end
                end
                default: ;
            endcase
        end
    end

    // Read data registered one cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= sfg_pkg::RST_ZERO;
        end else if (reg_rd) begin
            unique case (reg_addr)
                sfg_pkg::OFS_START_A:  reg_rdata <= start_a_reg;
                sfg_pkg::OFS_START_B:  reg_rdata <= start_b_reg;
                sfg_pkg::OFS_ROW_CNT:  reg_rdata <= row_cnt_reg;
                sfg_pkg::OFS_COL_CNT:  reg_rdata <= col_cnt_reg;
                sfg_pkg::OFS_HBLANK:   reg_rdata <= hblank_reg;
                sfg_pkg::OFS_VBLANK:   reg_rdata <= vblank_reg;
                sfg_pkg::OFS_RD_CTRL:  reg_rdata <= rd_ctrl_reg;
                sfg_pkg::OFS_ROW_RED:  reg_rdata <= row_red_reg;
                sfg_pkg::OFS_COL_RED:  reg_rdata <= col_red_reg;
                sfg_pkg::OFS_GAIN_G1:  reg_rdata <= gain_reg[1];
                sfg_pkg::OFS_GAIN_B:   reg_rdata <= gain_reg[3];
                sfg_pkg::OFS_GAIN_R:   reg_rdata <= gain_reg[0];
                sfg_pkg::OFS_GAIN_G2:  reg_rdata <= gain_reg[2];
                sfg_pkg::OFS_GAIN_ALL: reg_rdata <= gain_reg[1];
                // Low bits show the live black estimate
                sfg_pkg::OFS_BLK_CTRL: reg_rdata <= {blk_ctrl_reg[15],
                    15'(blk_est_reg)};
                default:               reg_rdata <= sfg_pkg::RST_ZERO;
            endcase
        end
    end

    // Two-entry output buffer
    logic [PIX_W-1:0] buf_mem [2];
    logic             wr_ptr_reg, rd_ptr_reg;
    logic [1:0]       cnt_reg;
    logic             buf_in_ready, buf_push, buf_pop;
    logic [PIX_W-1:0] gained;
    assign buf_in_ready = (cnt_reg != 2'h2);
    assign buf_push     = (state_reg == SFG_PUSH) && buf_in_ready;
    assign buf_pop      = pix_valid && pix_ready;
    assign pix_valid    = (cnt_reg != 2'h0);
    assign pix_data     = buf_mem[rd_ptr_reg];

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            cnt_reg    <= 2'h0;
            buf_mem[0] <= '0;
            buf_mem[1] <= '0;
        end else begin
            if (buf_push) begin
                buf_mem[wr_ptr_reg] <= gained;
                wr_ptr_reg          <= ~wr_ptr_reg;
            end
            if (buf_pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            cnt_reg <= cnt_reg + 2'(buf_push) - 2'(buf_pop);
        end
    end

    // Bin average, black subtraction and gain
    logic [SUM_W-1:0]   avg;
    logic [SUM_W+5:0]   ninth;
    logic [PIX_W-1:0]   blk, net;
    logic [15:0]        g;
    logic [14:0]        factor;
    logic [PIX_W+14:0]  prod, scaled;
    always_comb begin
        ninth = sum_reg * sfg_pkg::NINTH_MUL;
        if (row_bin == 2'h0 && col_bin == 2'h0) begin
            avg = sum_reg;
        end else if (row_bin == sfg_pkg::BIN_2X
                     && col_bin == sfg_pkg::BIN_2X) begin
            avg = sum_reg >> 2;
        end else begin
            avg = SUM_W'(ninth >> sfg_pkg::NINTH_SHIFT);
        end
        blk = blk_ctrl_reg[sfg_pkg::BLK_AUTO] ? blk_est_reg
                                              : PIX_W'(blk_ctrl_reg);
        net = (avg[PIX_W-1:0] > blk) ? avg[PIX_W-1:0] - blk : '0;
        g   = gain_reg[plane_reg];
        factor = 15'({1'b0, g[sfg_pkg::G1ST_BIT]} + 2'h1)
                 * 15'(g[sfg_pkg::G2ND_MSB:0])
                 * 15'(sfg_pkg::DIG_ONE
                       + 8'(g[sfg_pkg::DIG_MSB:sfg_pkg::DIG_LSB]));
        prod   = (PIX_W+15)'(net) * (PIX_W+15)'(factor);
        scaled = prod >> sfg_pkg::GAIN_SHIFT;
        // Saturate rather than wrap on high gain
        gained = (scaled > (PIX_W+15)'({PIX_W{1'b1}})) ? {PIX_W{1'b1}}
                                                       : PIX_W'(scaled);
    end

    // Readout sequencer
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg     <= SFG_VBLANK;
            row_off_reg   <= 16'h0000;
            col_off_reg   <= 16'h0000;
            row_ph_reg    <= 1'b0;
            col_ph_reg    <= 1'b0;
            bi_reg        <= 2'h0;
            bj_reg        <= 2'h0;
            sum_reg       <= '0;
            plane_reg     <= sfg_pkg::COL_R;
            blank_cnt_reg <= 16'h0000;
            vrow_reg      <= 16'h0000;
            vb_line_reg   <= 1'b0;
            fv_reg        <= 1'b0;
            arr_row       <= '0;
            arr_col       <= '0;
        end else begin
            unique case (state_reg)
                SFG_VBLANK: begin
                    // Each blank row: a blank period then a line period
                    blank_cnt_reg <= blank_cnt_reg + 16'h0001;
                    if (vrow_reg >= vblank_reg) begin
                        state_reg     <= SFG_READ;
                        fv_reg        <= 1'b1;
                        vrow_reg      <= 16'h0000;
                        blank_cnt_reg <= 16'h0000;
                        vb_line_reg   <= 1'b0;
                    end else if (!vb_line_reg
                                 && blank_cnt_reg >= hblank_reg) begin
                        vb_line_reg   <= 1'b1;
                        blank_cnt_reg <= 16'h0000;
                    end else if (vb_line_reg
                                 && blank_cnt_reg >= col_cnt_reg) begin
                        vb_line_reg   <= 1'b0;
                        blank_cnt_reg <= 16'h0000;
                        vrow_reg      <= vrow_reg + 16'h0001;
                    end
                end
                SFG_READ: begin
                    arr_row   <= ADR_W'(arow_w);
                    arr_col   <= ADR_W'(acol_w);
                    state_reg <= SFG_WAIT;
                    if (bi_reg == 2'h0 && bj_reg == 2'h0) begin
                        plane_reg <= plane_of(arow_w[0], acol_w[0]);
                        sum_reg   <= '0;
                    end
                end
                SFG_WAIT: begin
                    sum_reg <= sum_reg + SUM_W'(arr_data);
                    if (!last_bi) begin
                        bi_reg    <= bi_reg + 2'h1;
                        state_reg <= SFG_READ;
                    end else if (!last_bj) begin
                        bi_reg    <= 2'h0;
                        bj_reg    <= bj_reg + 2'h1;
                        state_reg <= SFG_READ;
                    end else begin
                        bi_reg    <= 2'h0;
                        bj_reg    <= 2'h0;
                        state_reg <= SFG_PUSH;
                    end
                end
                SFG_PUSH: begin
                    // Stalls here while the buffer is full
                    if (buf_in_ready) begin
                        if (row_end) begin
                            col_off_reg   <= 16'h0000;
                            col_ph_reg    <= 1'b0;
                            blank_cnt_reg <= 16'h0000;
                            state_reg     <= SFG_HBLANK;
                        end else begin
                            col_off_reg <= col_nx;
                            col_ph_reg  <= ~col_ph_reg;
                            state_reg   <= SFG_READ;
                        end
                    end
                end
                SFG_HBLANK: begin
                    blank_cnt_reg <= blank_cnt_reg + 16'h0001;
                    if (blank_cnt_reg >= hblank_reg) begin
                        blank_cnt_reg <= 16'h0000;
                        if (frame_end) begin
                            row_off_reg <= 16'h0000;
                            row_ph_reg  <= 1'b0;
                            fv_reg      <= 1'b0;
                            state_reg   <= SFG_VBLANK;
                        end else begin
                            row_off_reg <= row_nx;
                            row_ph_reg  <= ~row_ph_reg;
                            state_reg   <= SFG_READ;
                        end
                    end
                end
                default: state_reg <= SFG_VBLANK;
            endcase
        end
    end

    // Auto black: darkest pixel of the last frame
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            blk_est_reg   <= '0;
            frame_min_reg <= '1;
        end else if (state_reg == SFG_HBLANK && blank_cnt_reg >= hblank_reg
                     && frame_end) begin
            blk_est_reg   <= frame_min_reg;
            frame_min_reg <= '1;
        end else if (buf_push && avg[PIX_W-1:0] < frame_min_reg) begin
            frame_min_reg <= avg[PIX_W-1:0];
        end
    end

    // Row-valid format selection
    logic lv_active, lv_cont;
    always_comb begin
        lv_active = (state_reg == SFG_READ) || (state_reg == SFG_WAIT)
                    || (state_reg == SFG_PUSH);
        lv_cont   = lv_active || vb_line_reg;
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            frame_valid <= 1'b0;
            line_valid  <= 1'b0;
        end else begin
            frame_valid <= fv_reg;
            unique case (rd_ctrl_reg[sfg_pkg::LVF_MSB:
                                     sfg_pkg::LVF_LSB])
                sfg_pkg::LVF_NORMAL: line_valid <= lv_active;
                sfg_pkg::LVF_CONT:   line_valid <= lv_cont;
                default:             line_valid <= lv_cont ^ fv_reg;
            endcase
        end
    end
endmodule : sfg_readout

// file: testbench/sfg_host.sv
// Capture-side model: takes pixels, optionally stalling three cycles in four
`timescale 1ns/1ps
module sfg_host #(
    parameter int PIX_W = 12
) (
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic [PIX_W-1:0] pix_data,
    input wire logic             pix_valid,
    output logic                 pix_ready,
    input wire logic             stall_en
);
    logic [1:0]       ph_reg;
    logic [PIX_W-1:0] got_q [$];
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            ph_reg <= 2'h0;
        else
            ph_reg <= ph_reg + 2'h1;
    end
    // Slower than the pixel rate so the two-entry buffer fills and refuses
    assign pix_ready = !stall_en || ph_reg == 2'h3;
    always @(posedge ref_clk) begin
        if (rst_n && pix_valid && pix_ready)
            got_q.push_back(pix_data);
    end
endmodule : sfg_host

// file: testbench/sfg_readout_props.sv
// Port-level assertions for the readout-format and gain block
`timescale 1ns/1ps
module sfg_readout_props #(
    parameter int PIX_W = 12
) (
    input wire logic             ref_clk,
    input wire logic             rst_n,
    input wire logic [7:0]       reg_addr,
    input wire logic [15:0]      reg_wdata,
    input wire logic             reg_wr,
    input wire logic             reg_rd,
    input wire logic [15:0]      reg_rdata,
    input wire logic [PIX_W-1:0] pix_data,
    input wire logic             pix_valid,
    input wire logic             pix_ready,
    input wire logic             frame_valid,
    input wire logic             line_valid
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic [1:0] fmt_reg;
    logic       rw_hit;
    // Shadow of the row-valid format, so format checks need no peeking
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            fmt_reg <= 2'h0;
        else if (reg_wr && reg_addr == sfg_pkg::OFS_RD_CTRL)
            fmt_reg <= reg_wdata[10:9];
    end
    assign rw_hit = reg_addr inside {[8'h01:8'h06], 8'h20, 8'h22, 8'h23,
                                     [8'h2B:8'h2E]};
    sequence s_wr_rd;
        reg_wr && !reg_rd ##1 reg_rd && !reg_wr && $stable(reg_addr);
    endsequence
    sequence s_glob_rd;
        reg_wr && !reg_rd && reg_addr == 8'h35
        ##1 reg_rd && !reg_wr && reg_addr inside {[8'h2B:8'h2E]};
    endsequence
    a_readback_rw: assert property (s_wr_rd ##0 rw_hit
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("readback differs");
    a_global_fanout: assert property (s_glob_rd
        |=> reg_rdata == $past(reg_wdata, 2)) else $error("global not fanned");
    a_black_mode: assert property (s_wr_rd ##0 reg_addr == 8'h40
        |=> ((reg_rdata ^ $past(reg_wdata, 2)) & 16'h8000) == 16'h0000)
        else $error("black mode flag lost");
    a_unmapped_zero: assert property (reg_rd && reg_addr == 8'h10
        |=> reg_rdata == 16'h0000) else $error("unmapped read not zero");
    a_rdata_holds: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data moved without a read");
    a_pix_holds: assert property (pix_valid && !pix_ready
        |=> pix_valid && $stable(pix_data)) else $error("pixel lost in stall");
    a_line_in_frame: assert property (
        ($stable(fmt_reg) && fmt_reg == 2'h0) [*3] ##0 line_valid
        |-> frame_valid) else $error("row strobe outside frame");
    a_frame_opens_line: assert property (
        fmt_reg == 2'h0 && $rose(frame_valid) |-> ##[0:40] line_valid)
        else $error("frame without row strobe");
endmodule : sfg_readout_props
bind sfg_readout sfg_readout_props #(.PIX_W(PIX_W))
    sfg_readout_props_inst (.*);

// file: testbench/testbench.sv
// Self-checking bench for the readout-format and gain block
`timescale 1ns/1ps
module testbench;
    logic        ref_clk, rst_n, reg_wr, reg_rd, pix_valid, pix_ready;
    logic        frame_valid, line_valid, stall_en;
    logic [7:0]  reg_addr;
    logic [15:0] reg_wdata, reg_rdata;
    logic [11:0] arr_row, arr_col, arr_data, pix_data;
    int          n_mismatch, checks;
    sfg_readout sfg_readout_inst (.*);
    sfg_host sfg_host_inst (.*);
    // Array model: row*64+col+1, settled before the edge that samples it
    assign arr_data = 12'(arr_row * 64 + arr_col + 1);
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    function automatic logic [15:0] pv(int r, int c);
        return 16'(r * 64 + c + 1);
    endfunction : pv
    task automatic test_done;
        $display("Mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp
    task automatic bus(logic w, logic r, logic [7:0] a, logic [15:0] d);
        @(posedge ref_clk);
        #1;
        reg_wr = w;
        reg_rd = r;
        reg_addr = a;
        reg_wdata = d;
    endtask : bus
    task automatic rdc(logic [7:0] a, logic [15:0] e, logic [15:0] m);
        bus(1'b0, 1'b1, a, 16'h0000);
        bus(1'b0, 1'b0, a, 16'h0000);
        cmp($sformatf("reg %h", a), e & m, reg_rdata & m);
    endtask : rdc
    task automatic wr(logic [7:0] a, logic [15:0] d);
        bus(1'b1, 1'b0, a, d);
        bus(1'b0, 1'b0, a, d);
    endtask : wr
    // Bounded wait on frame_valid (s=0) or pix_valid (s=1)
    task automatic wt(int s, logic lvl);
        int i;
        for (i = 0; i < 90000 && (s ? pix_valid : frame_valid) !== lvl; i++)
            @(posedge ref_clk) #1;
        if (i == 90000) begin
            cmp("wait level", 16'(lvl), 16'(!lvl));
            test_done();
        end
    endtask : wt
    task automatic grab(int n);
        wt(0, 1'b1);
        wt(0, 1'b0);
        wt(1, 1'b0);
        sfg_host_inst.got_q.delete();
        wt(0, 1'b1);
        wt(0, 1'b0);
        wt(1, 1'b0);
        if (n >= 0)
            cmp("pixel count", 16'(n), 16'(sfg_host_inst.got_q.size()));
    endtask : grab
    task automatic pc(int k, logic [15:0] e);
        cmp($sformatf("pixel %0d", k), e, 16'(sfg_host_inst.got_q[k]));
    endtask : pc
    task automatic period(output int p);
        realtime t0;
        wt(0, 1'b0);
        wt(0, 1'b1);
        t0 = $realtime;
        wt(0, 1'b0);
        wt(0, 1'b1);
        p = int'(($realtime - t0) / 8.0);
    endtask : period
    task automatic t_reset_vals;
        logic [7:0] ra [15] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06,
            8'h20, 8'h22, 8'h23, 8'h2B, 8'h2C, 8'h2D, 8'h2E, 8'h35, 8'h10};
        logic [15:0] rv [15] = '{16'h0, 16'h0, 16'h05FF, 16'h07FF, 16'h0016,
            16'h0028, 16'h0, 16'h0, 16'h0, 16'h8, 16'h8, 16'h8, 16'h8, 16'h8,
            16'h0};
        for (int i = 0; i < 15; i++)
            rdc(ra[i], rv[i], 16'hFFFF);
    endtask : t_reset_vals
    task automatic t_regs;
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 1'b0, 8'h2B + 8'(i), 16'h0051 + 16'(i));
            rdc(8'h2B + 8'(i), 16'h0051 + 16'(i), 16'hFFFF);
        end
        bus(1'b1, 1'b0, 8'h35, 16'h0160);
        for (int i = 0; i < 4; i++)
            rdc(8'h2B + 8'(i), 16'h0160, 16'hFFFF);
        bus(1'b1, 1'b0, 8'h40, 16'h8000);
        rdc(8'h40, 16'h8000, 16'h8000);
        bus(1'b1, 1'b0, 8'h40, 16'h0000);
        rdc(8'h40, 16'h0000, 16'h8000);
        wr(8'h10, 16'hFFFF);
        rdc(8'h10, 16'h0000, 16'hFFFF);
        wr(8'h35, 16'h0008);
    endtask : t_regs
    task automatic t_frames;
        stall_en = 1'b1;
        grab(32);
        for (int k = 0; k < 32; k++)
            pc(k, pv(k / 8, k % 8));
        wr(8'h22, 16'h0001);
        wr(8'h23, 16'h0001);
        grab(8);
        for (int k = 0; k < 8; k++)
            pc(k, pv(k / 4, (k % 4) + ((k % 4) / 2) * 2));
        wr(8'h01, 16'h0002);
        wr(8'h02, 16'h0002);
        wr(8'h22, 16'h0000);
        wr(8'h23, 16'h0000);
        grab(32);
        pc(0, pv(2, 2));
        wr(8'h01, 16'h0000);
        wr(8'h02, 16'h0000);
        stall_en = 1'b0;
    endtask : t_frames
    task automatic t_gain;
        wr(8'h2D, 16'h0150);
        wr(8'h2B, 16'h0010);
        wr(8'h2C, 16'h0018);
        wr(8'h2E, 16'h0048);
        grab(32);
        pc(0, 16'd4);
        pc(2, 16'd13);
        pc(1, 16'd4);
        pc(8, 16'd130);
        pc(9, 16'd198);
        wr(8'h35, 16'h0008);
        wr(8'h22, 16'h0011);
        wr(8'h23, 16'h0011);
        grab(-1);
        pc(0, 16'd66);
        wr(8'h22, 16'h0022);
        wr(8'h23, 16'h0022);
        grab(-1);
        pc(0, 16'd131);
        wr(8'h22, 16'h0000);
        wr(8'h23, 16'h0000);
    endtask : t_gain
    task automatic t_blank_line;
        int p1, p2, seen;
        period(p1);
        wt(0, 1'b1);
        wr(8'h06, 16'h0006);
        period(p2);
        cmp("frame period delta", 16'd52, 16'(p2 - p1));
        wr(8'h06, 16'h0002);
        for (int f = 0; f < 3; f++) begin
            wr(8'h20, 16'(f) << 9);
            seen = 0;
            repeat (600) begin
                @(posedge ref_clk) #1;
                if (line_valid === 1'b1 && frame_valid === 1'b0)
                    seen = 1;
            end
            cmp("strobe in blanking", 16'(f != 0), 16'(seen));
        end
    endtask : t_blank_line
    initial begin
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 16'h0000;
        stall_en = 1'b0;
        n_mismatch = 0;
        checks = 0;
        repeat (5) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        t_reset_vals();
        wr(8'h06, 16'h0002);
        wr(8'h04, 16'h0007);
        wr(8'h03, 16'h0003);
        wr(8'h05, 16'h0004);
        t_regs();
        t_frames();
        t_gain();
        t_blank_line();
        test_done();
    end
endmodule : testbench
